// *** hdl/drive_safety_monitor.sv ***
// drive safety monitor: torque cut-off, stop hold, speed watch
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ns
`default_nettype none

// Contract
// - zero stop delay: cut torque at once on a stop request
// - stop request when safe input is zero or below minimum level
// - torque off forces pulse inhibit of the power stage
// - torque off always applies to every axis together
// - leave torque off only after cause gone, then acknowledge
// - stop hold keeps regulation and watches position window
// - stop hold window comes from the axis limit setting
// - any axis leaving its window forces torque off on all
// - hold violation acknowledged only back in window or hold left
// - nonzero stop delay: controlled stop, torque off after delay
// - delayed stop starts when safe input drops, delay nonzero
// - delay expiry forces torque off on all axes regardless
// - per-axis delayed hold stop when axis delay is nonzero
// - per-axis delayed stop starts when axis level becomes active
// - per-axis delayed stop runs independently with own settings
// - limited speed keeps regulation and checks velocity limit
// - speed limit comes from the axis limit setting
// - any axis over speed limit forces torque off on all
// - speed violation acknowledged only below limit or watch left
// - muted axes are not watched and never cause torque off
// - measured speed is averaged by a filter before comparison
module drive_safety_monitor
   import drive_safety_pkg::*;
#(
   parameter int unsigned MS_CYC = drive_safety_pkg::MS_CYCLES
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [drive_safety_pkg::ADDR_W-1:0] addr,
   input wire logic [drive_safety_pkg::DATA_W-1:0] wr_data,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [drive_safety_pkg::DATA_W-1:0] rd_data,
   input wire logic [drive_safety_pkg::LVL_W-1:0] safe_level_in,
   input wire logic [drive_safety_pkg::NUM_AXES*drive_safety_pkg::AX_LVL_W-1:0]
      axis_level_in,
   input wire drive_safety_pkg::axis_meas_t [drive_safety_pkg::NUM_AXES-1:0]
      meas,
   output logic torque_off,
   output logic [drive_safety_pkg::NUM_AXES-1:0] pulse_inhibit,
   output logic [drive_safety_pkg::NUM_AXES-1:0] axis_regulate,
   output logic drive_stop_running,
   output logic [drive_safety_pkg::NUM_AXES-1:0] hold_viol,
   output logic [drive_safety_pkg::NUM_AXES-1:0] speed_viol
);
   import drive_safety_pkg::*;

   function automatic logic axis_hit(input logic [ADDR_W-1:0] a,
                                     input int idx,
                                     input logic [ADDR_W-1:0] sub);
      logic [ADDR_W-1:0] ofs;
      ofs = AXIS_BASE_OFS + AXIS_STRIDE * ADDR_W'(idx) + sub;
      return a == ofs;
   endfunction

   function automatic logic [POS_W:0] abs_diff(input logic [POS_W-1:0] x,
                                               input logic [POS_W-1:0] y);
      logic signed [POS_W:0] d;
      d = $signed({x[POS_W-1], x}) - $signed({y[POS_W-1], y});
      return d[POS_W] ? (POS_W+1)'(-d) : d;
   endfunction

   logic [DLY_W-1:0] stop_dly_r;
   logic [LVL_W-1:0] min_lvl_r;
   axis_cfg_t ax_cfg_r [NUM_AXES];
   axis_lim_t ax_lim_r [NUM_AXES];
   logic ack;
   logic [DATA_W-1:0] rd_data_r;
   logic [DATA_W-1:0] rd_nxt;
   logic [DATA_W-1:0] status;

   logic [LVL_W-1:0] lvl_s1_r, lvl_s2_r, lvl_s3_r, lvl_r;
   logic [PRESC_W-1:0] presc_r;
   logic tick_r;
   logic drive_req;
   logic stop_run_r;
   logic [DLY_W:0] stop_cnt_r;
   logic torque_off_r;
   logic [NUM_AXES-1:0] pulse_inhibit_r, axis_regulate_r;
   logic [NUM_AXES-1:0] hold_viol_r, speed_viol_r;
   logic [NUM_AXES-1:0] hold_viol_nxt, speed_viol_nxt;
   logic [NUM_AXES-1:0] hold_act, speed_act, brake_act, muted;

   // ---------------- register port ----------------
   assign ack = wr_stb && addr == ACK_OFS && wr_data[ACK_BIT];

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         stop_dly_r <= STOP_DLY_RST;
         min_lvl_r <= MIN_LVL_RST;
      end
      else if (wr_stb && addr == DRIVE_CFG_OFS)
      begin
         stop_dly_r <= wr_data[DLY_LSB +: DLY_W];
         min_lvl_r <= wr_data[MIN_LVL_LSB +: LVL_W];
      end
   end

   always_comb
   begin
      status = '0;
      status[ST_TORQUE_OFF] = torque_off_r;
      status[ST_STOP_RUN] = stop_run_r;
      status[ST_HOLD_VIOL +: NUM_AXES] = hold_viol_r;
      status[ST_SPD_VIOL +: NUM_AXES] = speed_viol_r;
      status[ST_HOLD_ACT +: NUM_AXES] = hold_act;
      status[ST_SPD_ACT +: NUM_AXES] = speed_act;
      status[ST_LEVEL +: LVL_W] = lvl_r;
      status[ST_BRAKE +: NUM_AXES] = brake_act;
   end

   always_comb
   begin
      rd_nxt = '0;
      if (addr == DRIVE_CFG_OFS)
      begin
         rd_nxt[DLY_LSB +: DLY_W] = stop_dly_r;
         rd_nxt[MIN_LVL_LSB +: LVL_W] = min_lvl_r;
      end
      else if (addr == STATUS_OFS)
      begin
         rd_nxt = status;
      end
      for (int i = 0; i < NUM_AXES; i++)
      begin
         if (axis_hit(addr, i, AX_CFG_SUB))
         begin
            rd_nxt = DATA_W'(ax_cfg_r[i]);
         end
         if (axis_hit(addr, i, AX_LIM_SUB))
         begin
            rd_nxt = ax_lim_r[i];
         end
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rd_data_r <= '0;
      end
      else
      begin
         rd_data_r <= rd_stb ? rd_nxt : '0;
      end
   end

   // ---------------- safe input and timebase ----------------
   // a level change is taken once the last two stages agree
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         lvl_s1_r <= '0;
         lvl_s2_r <= '0;
         lvl_s3_r <= '0;
         lvl_r <= '0;
      end
      else
      begin
         lvl_s1_r <= safe_level_in;
         lvl_s2_r <= lvl_s1_r;
         lvl_s3_r <= lvl_s2_r;
         if (lvl_s2_r == lvl_s3_r)
         begin
            lvl_r <= lvl_s3_r;
         end
      end
   end

   // one shared millisecond tick for all delay timers
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         presc_r <= '0;
         tick_r <= 1'b0;
      end
      else
      begin
         tick_r <= presc_r == PRESC_W'(MS_CYC - 1);
         presc_r <= (presc_r == PRESC_W'(MS_CYC - 1)) ? '0 : presc_r + 1'b1;
      end
   end

   assign drive_req = lvl_r == '0 || lvl_r < min_lvl_r;

   // delayed stop start
   // loading delay+1 ticks makes the delay a least time despite the shared tick
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         stop_run_r <= 1'b0;
         stop_cnt_r <= '0;
      end
      else if (torque_off_r)
      begin
         stop_run_r <= 1'b0;
         stop_cnt_r <= '0;
      end
      else if (!stop_run_r && drive_req && stop_dly_r != '0)
      begin
         stop_run_r <= 1'b1;
         stop_cnt_r <= {1'b0, stop_dly_r} + 1'b1;
      end
      else if (stop_run_r && tick_r)
      begin
         stop_cnt_r <= stop_cnt_r - 1'b1;
      end
   end

   // ---------------- per-axis monitors ----------------
   genvar g;
   generate
      for (g = 0; g < NUM_AXES; g++)
      begin : g_axis
         logic [AX_LVL_W-1:0] s1_r, s2_r, s3_r, alvl_r;
         logic hold_sel, hold_sel_d_r, speed_sel;
         logic holding_r, brake_r;
         logic [DLY_W:0] brake_cnt_r;
         logic signed [POS_W-1:0] halt_pos_r;
         logic [POS_W:0] pos_err;
         logic out_of_win;
         logic [SPD_W-1:0] abs_spd, avg_r;
         logic signed [SPD_W:0] avg_diff, avg_step;
         logic over_spd;

         always_ff @(posedge clk)
         begin
            if (rst)
            begin
               ax_cfg_r[g] <= AX_CFG_RST;
               ax_lim_r[g] <= AX_LIM_RST;
            end
            else if (wr_stb && axis_hit(addr, g, AX_CFG_SUB))
            begin
               ax_cfg_r[g] <= axis_cfg_t'(wr_data[$bits(axis_cfg_t)-1:0]);
            end
            else if (wr_stb && axis_hit(addr, g, AX_LIM_SUB))
            begin
               ax_lim_r[g] <= wr_data;
            end
         end

         always_ff @(posedge clk)
         begin
            if (rst)
            begin
               s1_r <= '0;
               s2_r <= '0;
               s3_r <= '0;
               alvl_r <= '0;
            end
            else
            begin
               s1_r <= axis_level_in[g*AX_LVL_W +: AX_LVL_W];
               s2_r <= s1_r;
               s3_r <= s2_r;
               if (s2_r == s3_r)
               begin
                  alvl_r <= s3_r;
               end
            end
         end

         assign muted[g] = ax_cfg_r[g].muted;
         assign hold_sel = ax_cfg_r[g].hold_lvl != '0 &&
                           alvl_r == ax_cfg_r[g].hold_lvl;
         assign speed_sel = ax_cfg_r[g].speed_lvl != '0 &&
                            alvl_r == ax_cfg_r[g].speed_lvl;

         always_ff @(posedge clk)
         begin
            if (rst)
            begin
               hold_sel_d_r <= 1'b0;
               holding_r <= 1'b0;
               brake_r <= 1'b0;
               brake_cnt_r <= '0;
               halt_pos_r <= '0;
            end
            else
            begin
               hold_sel_d_r <= hold_sel;
               if (!hold_sel)
               begin
                  holding_r <= 1'b0;
                  brake_r <= 1'b0;
               end
               else if (!hold_sel_d_r && ax_cfg_r[g].hold_delay != '0)
               begin
                  brake_r <= 1'b1;
                  brake_cnt_r <= {1'b0, ax_cfg_r[g].hold_delay} + 1'b1;
               end
               else if (!hold_sel_d_r ||
                        (brake_r && tick_r && brake_cnt_r == 1))
               begin
                  brake_r <= 1'b0;
                  holding_r <= 1'b1;
                  halt_pos_r <= meas[g].pos;
               end
               else if (brake_r && tick_r)
               begin
                  brake_cnt_r <= brake_cnt_r - 1'b1;
               end
            end
         end

         assign pos_err = abs_diff(meas[g].pos, halt_pos_r);
         assign out_of_win = pos_err > {17'h00000, ax_lim_r[g].hold_window};

         always_comb
         begin
            hold_viol_nxt[g] = hold_viol_r[g];
            if (ack && (!out_of_win || !holding_r))
            begin
               hold_viol_nxt[g] = 1'b0;
            end
            if (holding_r && !muted[g] && out_of_win)
            begin
               hold_viol_nxt[g] = 1'b1;
            end
         end

         // speed averaging
         // first-order filter: shift n spans about 2^n cycles, no divider
         assign abs_spd = meas[g].speed[SPD_W-1] ?
                          SPD_W'(-meas[g].speed) : meas[g].speed;
         assign avg_diff = $signed({1'b0, abs_spd}) - $signed({1'b0, avg_r});
         assign avg_step = avg_diff >>> ax_cfg_r[g].filt_shift;

         always_ff @(posedge clk)
         begin
            if (rst)
            begin
               avg_r <= '0;
            end
            else
            begin
               avg_r <= avg_r + avg_step[SPD_W-1:0];
            end
         end

         assign over_spd = avg_r > ax_lim_r[g].speed_limit;

         always_comb
         begin
            speed_viol_nxt[g] = speed_viol_r[g];
            if (ack && (!over_spd || !speed_sel))
            begin
               speed_viol_nxt[g] = 1'b0;
            end
            if (speed_sel && !muted[g] && over_spd)
            begin
               speed_viol_nxt[g] = 1'b1;
            end
         end

         assign hold_act[g] = holding_r;
         assign brake_act[g] = brake_r;
         assign speed_act[g] = speed_sel;
      end
   endgenerate

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         hold_viol_r <= '1;
         speed_viol_r <= '1;
      end
      else
      begin
         hold_viol_r <= hold_viol_nxt;
         speed_viol_r <= speed_viol_nxt;
      end
   end

   // ---------------- torque-off latch ----------------
   logic set_off, viol_now;
   assign viol_now = |((hold_viol_nxt | speed_viol_nxt) & ~muted);
   assign set_off = (drive_req && stop_dly_r == '0) || viol_now ||
                    (stop_run_r && tick_r && stop_cnt_r == 1);

   // restart lock
   // set wins over acknowledge in the same cycle
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         torque_off_r <= 1'b1;
      end
      else if (set_off)
      begin
         torque_off_r <= 1'b1;
      end
      else if (ack && !drive_req && !stop_run_r)
      begin
         torque_off_r <= 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pulse_inhibit_r <= '1;
         axis_regulate_r <= '0;
      end
      else
      begin
         pulse_inhibit_r <= {NUM_AXES{torque_off_r}};
         axis_regulate_r <= {NUM_AXES{!torque_off_r}};
      end
   end

   assign rd_data = rd_data_r;
   assign torque_off = torque_off_r;
   assign pulse_inhibit = pulse_inhibit_r;
   assign axis_regulate = axis_regulate_r;
   assign drive_stop_running = stop_run_r;
   assign hold_viol = hold_viol_r;
   assign speed_viol = speed_viol_r;

endmodule

`default_nettype wire

// *** hdl/drive_safety_pkg.sv ***
// constants, register map and carrier types of the drive safety monitor
package drive_safety_pkg;

   localparam int NUM_AXES = 4;
   localparam int POS_W = 32;
   localparam int SPD_W = 16;
   localparam int LVL_W = 4;
   localparam int AX_LVL_W = 2;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // timing: delays are programmed in milliseconds
   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam int unsigned MS_NS = 1000000;
   localparam int unsigned MS_CYCLES = MS_NS / CLK_PERIOD_NS;
   localparam int PRESC_W = 16;
   localparam int DLY_W = 16;

   // register byte offsets
   localparam logic [ADDR_W-1:0] DRIVE_CFG_OFS = 8'h00;
   localparam logic [ADDR_W-1:0] ACK_OFS = 8'h04;
   localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h08;
   localparam logic [ADDR_W-1:0] AXIS_BASE_OFS = 8'h10;
   localparam logic [ADDR_W-1:0] AXIS_STRIDE = 8'h08;
   localparam logic [ADDR_W-1:0] AX_CFG_SUB = 8'h00;
   localparam logic [ADDR_W-1:0] AX_LIM_SUB = 8'h04;

   // drive_cfg fields
   localparam int DLY_LSB = 0;
   localparam int MIN_LVL_LSB = 16;
   // ack field
   localparam int ACK_BIT = 0;
   // status fields
   localparam int ST_TORQUE_OFF = 0;
   localparam int ST_STOP_RUN = 1;
   localparam int ST_HOLD_VIOL = 4;
   localparam int ST_SPD_VIOL = 8;
   localparam int ST_HOLD_ACT = 12;
   localparam int ST_SPD_ACT = 16;
   localparam int ST_LEVEL = 20;
   localparam int ST_BRAKE = 24;

   // reset values
   localparam logic [DLY_W-1:0] STOP_DLY_RST = 16'h0000;
   localparam logic [LVL_W-1:0] MIN_LVL_RST = 4'h1;

   typedef struct packed {
      logic [DLY_W-1:0] hold_delay;
      logic [3:0] filt_shift;
      logic [AX_LVL_W-1:0] speed_lvl;
      logic [AX_LVL_W-1:0] hold_lvl;
      logic [2:0] spare;
      logic muted;
   } axis_cfg_t;

   typedef struct packed {
      logic [15:0] speed_limit;
      logic [15:0] hold_window;
   } axis_lim_t;

   typedef struct packed {
      logic signed [POS_W-1:0] pos;
      logic signed [SPD_W-1:0] speed;
   } axis_meas_t;

   localparam axis_cfg_t AX_CFG_RST = '{hold_delay: 16'h0000,
      filt_shift: 4'h0, speed_lvl: 2'h2, hold_lvl: 2'h1, spare: 3'h0,
      muted: 1'b0};
   localparam axis_lim_t AX_LIM_RST = '{speed_limit: 16'h0000,
      hold_window: 16'h0000};

endpackage

// *** test/drive_safety_asserts.sv ***
// port checker for the drive safety monitor
`timescale 1ns/1ns
`default_nettype none
module drive_safety_asserts
   import drive_safety_pkg::*;
#(
   parameter int unsigned MS_CYC = 25000
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [drive_safety_pkg::ADDR_W-1:0] addr,
   input wire logic [drive_safety_pkg::DATA_W-1:0] wr_data,
   input wire logic wr_stb,
   input wire logic [drive_safety_pkg::LVL_W-1:0] safe_level_in,
   input wire logic torque_off,
   input wire logic [drive_safety_pkg::NUM_AXES-1:0] pulse_inhibit,
   input wire logic [drive_safety_pkg::NUM_AXES-1:0] axis_regulate,
   input wire logic drive_stop_running,
   input wire logic [drive_safety_pkg::NUM_AXES-1:0] hold_viol,
   input wire logic [drive_safety_pkg::NUM_AXES-1:0] speed_viol
);
   logic [DLY_W-1:0] dly_r;
   logic [LVL_W-1:0] min_r;
   logic [NUM_AXES-1:0] mute_r;
   int run_cnt;
   logic ack_w;
   logic stop_req;
   assign ack_w = wr_stb && addr == ACK_OFS && wr_data[ACK_BIT];
   assign stop_req = safe_level_in == 4'h0 || safe_level_in < min_r;

   // shadow of the settings the assertions depend on
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         dly_r <= STOP_DLY_RST;
         min_r <= MIN_LVL_RST;
         mute_r <= {NUM_AXES{AX_CFG_RST.muted}};
      end
      else if (wr_stb)
      begin
         if (addr == DRIVE_CFG_OFS)
         begin
            dly_r <= wr_data[DLY_LSB +: DLY_W];
            min_r <= wr_data[MIN_LVL_LSB +: LVL_W];
         end
         for (int a = 0; a < NUM_AXES; a++)
            if (addr == 8'(AXIS_BASE_OFS + AXIS_STRIDE * a + AX_CFG_SUB))
               mute_r[a] <= wr_data[0];
      end
   end

   // cycles spent in the delayed stop before torque is cut
   always_ff @(posedge clk)
   begin
      if (rst || !drive_stop_running || torque_off)
         run_cnt <= 0;
      else
         run_cnt <= run_cnt + 1;
   end

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   reset_state_a: assert property ($fell(rst) |-> torque_off &&
      hold_viol == 4'hf && speed_viol == 4'hf && !drive_stop_running)
      else $error("state after reset wrong");
   inhibit_all_a: assert property (
      pulse_inhibit == {NUM_AXES{$past(torque_off)}})
      else $error("pulse inhibit not following torque off");
   regulate_a: assert property (axis_regulate == ~pulse_inhibit)
      else $error("regulation not opposite to inhibit");
   immediate_stop_a: assert property (
      (stop_req && dly_r == 16'h0)[*8] |-> torque_off)
      else $error("torque not cut on stop request");
   delayed_start_a: assert property (
      (safe_level_in == 4'h0 && dly_r != 16'h0)[*8] |->
      drive_stop_running || torque_off)
      else $error("delayed stop not started");
   delay_bound_a: assert property (
      run_cnt <= (int'(dly_r) + 1) * int'(MS_CYC) + 8)
      else $error("delayed stop overran its time");
   hold_trip_a: assert property (
      |(hold_viol & ~$past(hold_viol) & ~mute_r) |-> torque_off)
      else $error("hold violation without torque off");
   speed_trip_a: assert property (
      |(speed_viol & ~$past(speed_viol) & ~mute_r) |-> torque_off)
      else $error("speed violation without torque off");
   release_ack_a: assert property ($fell(torque_off) |->
      $past(ack_w) || $past(ack_w, 2))
      else $error("torque off left without acknowledge");
   viol_ack_a: assert property (
      |($past(hold_viol | speed_viol) & ~(hold_viol | speed_viol)) |->
      $past(ack_w) || $past(ack_w, 2))
      else $error("violation cleared without acknowledge");

   cover property ($rose(torque_off));
   cover property ($rose(drive_stop_running));
   cover property ($fell(torque_off));
endmodule

bind drive_safety_monitor drive_safety_asserts #(.MS_CYC(MS_CYC)) i_chk (
   .clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data),
   .wr_stb(wr_stb), .safe_level_in(safe_level_in), .torque_off(torque_off),
   .pulse_inhibit(pulse_inhibit), .axis_regulate(axis_regulate),
   .drive_stop_running(drive_stop_running), .hold_viol(hold_viol),
   .speed_viol(speed_viol));
`default_nettype wire

// *** test/plant_model.sv ***
// plant model: safe input pin, axis level pins and axis encoders
`timescale 1ns/1ns
`default_nettype none
module plant_model
   import drive_safety_pkg::*;
(
   input wire logic clk,
   output var logic [drive_safety_pkg::LVL_W-1:0] safe_level_in,
   output var logic [drive_safety_pkg::NUM_AXES*drive_safety_pkg::AX_LVL_W-1:0]
      axis_level_in,
   output var drive_safety_pkg::axis_meas_t [drive_safety_pkg::NUM_AXES-1:0]
      meas
);
   initial
   begin
      safe_level_in = 4'hf;
      axis_level_in = '0;
      meas = '0;
   end

   task set_safe(input logic [3:0] v);
      @(posedge clk);
      safe_level_in <= v;
   endtask

   task set_lvl(input int a, input logic [1:0] v);
      @(posedge clk);
      axis_level_in[2*a +: 2] <= v;
   endtask

   task set_meas(input int a, input int p, input int s);
      @(posedge clk);
      meas[a] <= '{pos: 32'(p), speed: 16'(s)};
   endtask
endmodule
`default_nettype wire

// *** test/test_drive_safety_monitor.sv ***
// self-checking bench for the drive safety monitor
`timescale 1ns/1ns
`default_nettype none
module test_drive_safety_monitor;
   import drive_safety_pkg::*;
   localparam int MS = 20;
   logic clk = 1'b0;
   logic rst;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wr_data;
   logic wr_stb;
   logic rd_stb;
   logic [DATA_W-1:0] rd_data;
   logic [LVL_W-1:0] safe_level_in;
   logic [NUM_AXES*AX_LVL_W-1:0] axis_level_in;
   axis_meas_t [NUM_AXES-1:0] meas;
   logic torque_off;
   logic drive_stop_running;
   logic [NUM_AXES-1:0] pulse_inhibit, axis_regulate, hold_viol, speed_viol;
   int error_cnt = 0;
   int tests_run = 0;
   logic [31:0] st;

   always #20 clk = ~clk;

   plant_model i_plant (.clk(clk), .safe_level_in(safe_level_in),
      .axis_level_in(axis_level_in), .meas(meas));

   drive_safety_monitor #(.MS_CYC(MS)) i_dut (.clk(clk), .rst(rst),
      .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
      .rd_data(rd_data), .safe_level_in(safe_level_in),
      .axis_level_in(axis_level_in), .meas(meas), .torque_off(torque_off),
      .pulse_inhibit(pulse_inhibit), .axis_regulate(axis_regulate),
      .drive_stop_running(drive_stop_running), .hold_viol(hold_viol),
      .speed_viol(speed_viol));

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1;
      d = rd_data;
   endtask

   task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] g);
      tests_run++;
      if (g !== e)
      begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask

   function automatic logic [7:0] ax(input int a, input logic [7:0] s);
      return 8'(AXIS_BASE_OFS + AXIS_STRIDE * a + s);
   endfunction

   task automatic ack();
      wr(ACK_OFS, 32'h1);
      cyc(3);
   endtask

   task automatic restore();
      i_plant.set_safe(4'hf);
      cyc(6);
      ack();
      chk("torque_off", 32'h0, torque_off);
   endtask

   task automatic t_reset();
      chk("torque_off", 32'h1, torque_off);
      chk("hold_viol", 32'hf, hold_viol);
      chk("speed_viol", 32'hf, speed_viol);
      rd(DRIVE_CFG_OFS, st);
      chk("drive_cfg", {12'h0, MIN_LVL_RST, STOP_DLY_RST}, st);
      rd(ax(2, AX_CFG_SUB), st);
      chk("axis_cfg", 32'(AX_CFG_RST), st);
      rd(ax(2, AX_LIM_SUB), st);
      chk("axis_lim", 32'(AX_LIM_RST), st);
      rd(8'hfc, st);
      chk("unmapped", 32'h0, st);
      wr(STATUS_OFS, 32'h0);
      rd(STATUS_OFS, st);
      chk("status_off", 32'h1, st[ST_TORQUE_OFF]);
      restore();
      chk("axis_regulate", 32'hf, axis_regulate);
      chk("hold_viol", 32'h0, hold_viol);
      $display("reset test finished");
   endtask

   task automatic t_stop();
      i_plant.set_safe(4'h0);
      cyc(7);
      chk("torque_off", 32'h1, torque_off);
      chk("pulse_inhibit", 32'hf, pulse_inhibit);
      ack();
      chk("torque_off", 32'h1, torque_off);
      restore();
      wr(DRIVE_CFG_OFS, {12'h0, 4'h5, 16'h0});
      i_plant.set_safe(4'h4);
      cyc(7);
      chk("torque_off", 32'h1, torque_off);
      i_plant.set_safe(4'h5);
      cyc(6);
      ack();
      chk("torque_off", 32'h0, torque_off);
      $display("stop test finished");
   endtask

   task automatic t_delay();
      wr(DRIVE_CFG_OFS, {12'h0, 4'h5, 16'h2});
      i_plant.set_safe(4'h0);
      cyc(7);
      chk("stop_running", 32'h1, drive_stop_running);
      chk("axis_regulate", 32'hf, axis_regulate);
      i_plant.set_safe(4'hf);
      cyc(2 * MS - 10);
      chk("torque_off", 32'h0, torque_off);
      cyc(MS + 12);
      chk("pulse_inhibit", 32'hf, pulse_inhibit);
      ack();
      chk("torque_off", 32'h0, torque_off);
      wr(DRIVE_CFG_OFS, {12'h0, 4'h1, 16'h0});
      $display("delayed stop test finished");
   endtask

   task automatic t_hold();
      axis_cfg_t c;
      c = AX_CFG_RST;
      c.hold_delay = 16'h1;
      wr(ax(1, AX_CFG_SUB), 32'(c));
      wr(ax(1, AX_LIM_SUB), {16'hffff, 16'h0010});
      i_plant.set_meas(1, 100, 0);
      i_plant.set_lvl(1, 2'h1);
      cyc(7);
      rd(STATUS_OFS, st);
      chk("brake1", 32'h1, st[ST_BRAKE + 1]);
      chk("brake0", 32'h0, st[ST_BRAKE]);
      cyc(2 * MS + 4);
      rd(STATUS_OFS, st);
      chk("hold_act1", 32'h1, st[ST_HOLD_ACT + 1]);
      i_plant.set_meas(1, 116, 0);
      cyc(3);
      chk("torque_off", 32'h0, torque_off);
      i_plant.set_meas(1, 117, 0);
      cyc(3);
      chk("hold_viol", 32'h2, hold_viol);
      chk("pulse_inhibit", 32'hf, pulse_inhibit);
      ack();
      chk("hold_viol", 32'h2, hold_viol);
      i_plant.set_meas(1, 100, 0);
      ack();
      chk("hold_viol", 32'h0, hold_viol);
      chk("torque_off", 32'h0, torque_off);
      i_plant.set_lvl(1, 2'h0);
      $display("hold test finished");
   endtask

   task automatic t_speed();
      axis_cfg_t c;
      c = AX_CFG_RST;
      c.filt_shift = 4'h2;
      wr(ax(0, AX_CFG_SUB), 32'(c));
      c.muted = 1'b1;
      wr(ax(3, AX_CFG_SUB), 32'(c));
      wr(ax(0, AX_LIM_SUB), {16'h0064, 16'h0000});
      wr(ax(3, AX_LIM_SUB), {16'h000a, 16'h0000});
      i_plant.set_meas(3, 0, 500);
      i_plant.set_lvl(3, 2'h2);
      i_plant.set_lvl(0, 2'h2);
      cyc(10);
      chk("torque_off", 32'h0, torque_off);
      i_plant.set_meas(0, 0, 200);
      i_plant.set_meas(0, 0, 100);
      cyc(40);
      chk("speed_viol0", 32'h0, speed_viol[0]);
      i_plant.set_meas(0, 0, -150);
      cyc(20);
      chk("speed_viol0", 32'h1, speed_viol[0]);
      chk("torque_off", 32'h1, torque_off);
      ack();
      chk("speed_viol0", 32'h1, speed_viol[0]);
      i_plant.set_meas(0, 0, 0);
      cyc(40);
      ack();
      chk("speed_viol0", 32'h0, speed_viol[0]);
      chk("torque_off", 32'h0, torque_off);
      $display("speed test finished");
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // the whole sequence needs well under two thousand cycles
   initial
   begin
      cyc(5000);
      error_cnt++;
      finish_test();
   end

   initial
   begin
      rst <= 1'b1;
      addr <= '0;
      wr_data <= '0;
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      cyc(10);
      rst <= 1'b0;
      t_reset();
      t_stop();
      t_delay();
      t_hold();
      t_speed();
      finish_test();
   end
endmodule
`default_nettype wire
